// ### cbat_pkg.sv
package cbat_pkg;

  // ----------------------------------------
  // Widths and timing
  // ----------------------------------------
  localparam int CBAT_COUNT_W = 16;
  localparam int CBAT_CS_W = 3;
  localparam int CBAT_COMP_W = 5;
  localparam int CBAT_GAIN_SEL_W = 2;
  localparam int CBAT_CLK_MHZ = 100;
  localparam int CBAT_XFER_NS = 1000;
  localparam int CBAT_XFER_CYCLES = (CBAT_XFER_NS * CBAT_CLK_MHZ + 999) / 1000;
  localparam logic [15:0] CBAT_XFER_TOP = 16'(CBAT_XFER_CYCLES - 1);
  localparam logic [15:0] CBAT_MAX_BURST = 16'hfff0;

  // ----------------------------------------
  // Tuning targets
  // ----------------------------------------
  localparam logic [15:0] CBAT_TUNE_TARGET = 16'h0800;
  localparam logic [15:0] CBAT_TUNE_WINDOW = 16'h0100;
  localparam logic [15:0] CBAT_GAIN_TARGET_0 = 16'h0a00;
  localparam logic [15:0] CBAT_GAIN_TARGET_1 = 16'h0c00;
  localparam logic [15:0] CBAT_GAIN_TARGET_2 = 16'h0e00;
  localparam logic [15:0] CBAT_GAIN_TARGET_3 = 16'h1000;
  localparam logic [CBAT_CS_W-1:0] CBAT_CS_LAST = 3'h7;
  localparam logic [CBAT_COMP_W-1:0] CBAT_COMP_LAST = 5'h1f;
  localparam logic [5:0] CBAT_AVG_COUNT = 6'h2c;
  localparam logic [1:0] CBAT_RST_MODE = 2'h0;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    CBAT_MODE_CONTROL = 2'h0,
    CBAT_MODE_DUAL = 2'h1,
    CBAT_MODE_STREAM = 2'h2
  } cbat_mode_type;

  typedef enum logic [2:0] {
    CBAT_ST_CS = 3'h0,
    CBAT_ST_COMP = 3'h1,
    CBAT_ST_AVG = 3'h3,
    CBAT_ST_RUN = 3'h2
  } cbat_state_type;

  typedef struct packed {
    logic tuning;
    logic [CBAT_CS_W-1:0] cs_sel;
    logic [CBAT_COMP_W-1:0] comp_sel;
    logic [CBAT_COUNT_W-1:0] burst_count;
  } cbat_stream_type;

endpackage : cbat_pkg

// ### cbat_burst.sv
`timescale 1ns/1ps
`default_nettype none
module cbat_burst
  import cbat_pkg::*;
(
  input wire logic clk_sys, // System clock
  input wire logic sys_rst, // Async reset
  input wire logic start, // Begin a burst
  input wire logic trip_sync, // Synchronised comparator
  output logic xfer_pulse, // One transfer strobe
  output logic busy, // Burst under way
  output logic done, // Burst finished pulse
  output logic [CBAT_COUNT_W-1:0] count // Transfers in last burst
);

  logic [15:0] div;
  logic [CBAT_COUNT_W-1:0] run;

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      div <= 16'h0000;
    else if (!busy || div == CBAT_XFER_TOP)
      div <= 16'h0000;
    else
      div <= div + 16'h0001;
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      busy <= 1'b0;
      done <= 1'b0;
      run <= '0;
      count <= '0;
      xfer_pulse <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      xfer_pulse <= 1'b0;
      if (!busy)
      begin
        if (start)
        begin
          busy <= 1'b1;
          run <= '0;
        end
      end
      // Stop on trip, or cap a stuck channel
      else if (trip_sync || run == CBAT_MAX_BURST)
      begin
        busy <= 1'b0;
        done <= 1'b1;
        count <= run;
      end
      else if (div == CBAT_XFER_TOP)
      begin
        xfer_pulse <= 1'b1;
        run <= run + 16'h0001;
      end
    end
  end

endmodule : cbat_burst
`default_nettype wire

// ### cbat_tuner.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Count transfers until comparator trips
// - Startup picks sample cap nearest gain target
// - Then raise compensation until count reaches tuning target minus window
// - Window is target plus or minus 256
// - Keep found compensation during normal operation
// - Tune at startup and when burst count leaves window
// - No detection events while tuning
// - Streaming shows tuning flag and settings
// - Gain target chosen by fixed option field
// - Mode sets pin roles
// - Reference averages 44 bursts taken after compensation search
module cbat_tuner
  import cbat_pkg::*;
(
  input wire logic clk_sys, // System clock
  input wire logic sys_rst, // Async reset
  input wire logic [1:0] cfg_mode, // Output mode option
  input wire logic [CBAT_GAIN_SEL_W-1:0] cfg_gain_sel, // Gain target option
  input wire logic burst_trip, // Comparator from front end
  input wire logic touch_event, // Touch from detector
  input wire logic prox_event, // Proximity from detector
  input wire logic host_ctrl_in, // Host control pin
  output logic xfer_pulse, // Transfer strobe to front end
  output logic [CBAT_CS_W-1:0] cs_sel, // Sample cap code
  output logic [CBAT_COMP_W-1:0] parasitic_offset_comp, // Compensation code
  output logic [CBAT_COUNT_W-1:0] reference, // Averaged reference
  output logic detect_enable, // Detection allowed
  output logic host_ctrl, // Synchronised host input
  output logic touch_detect_pin, // Pin 1 driven level
  output logic touch_detect_pin_oe, // Pin 1 enable
  output logic proximity_detect_pin, // Pin 8 driven level
  output logic proximity_detect_pin_oe, // Pin 8 enable
  output cbat_stream_type stream_data // Streaming payload
);

  cbat_state_type state;
  cbat_mode_type mode;
  logic cfg_taken;
  logic [CBAT_GAIN_SEL_W-1:0] gain_sel;
  logic [1:0] trip_ff;
  logic [1:0] ctrl_ff;
  logic start;
  logic busy;
  logic done;
  logic [CBAT_COUNT_W-1:0] count;
  logic [CBAT_COUNT_W-1:0] best_err;
  logic [CBAT_CS_W-1:0] best_cs;
  logic [21:0] acc;
  logic [5:0] avg_n;
  logic [CBAT_COUNT_W-1:0] err;

  function automatic logic [CBAT_COUNT_W-1:0] abs_diff(input logic [CBAT_COUNT_W-1:0] a,
                                                      input logic [CBAT_COUNT_W-1:0] b);
    abs_diff = (a > b) ? a - b : b - a;
  endfunction : abs_diff

  function automatic logic [CBAT_COUNT_W-1:0] gain_target(input logic [CBAT_GAIN_SEL_W-1:0] s);
    case (s)
      2'h0: gain_target = CBAT_GAIN_TARGET_0;
      2'h1: gain_target = CBAT_GAIN_TARGET_1;
      2'h2: gain_target = CBAT_GAIN_TARGET_2;
      default: gain_target = CBAT_GAIN_TARGET_3;
    endcase
  endfunction : gain_target

  // ----------------------------------------
  // Pin synchronisers and option capture
  // ----------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      trip_ff <= 2'h0;
      ctrl_ff <= 2'h0;
    end
    else
    begin
      trip_ff <= {trip_ff[0], burst_trip};
      ctrl_ff <= {ctrl_ff[0], host_ctrl_in};
    end
  end

  // Options are latched once after reset, later changes are ignored
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cfg_taken <= 1'b0;
      gain_sel <= '0;
      mode <= cbat_mode_type'(CBAT_RST_MODE);
    end
    else if (!cfg_taken)
    begin
      cfg_taken <= 1'b1;
      gain_sel <= cfg_gain_sel;
      mode <= cbat_mode_type'(cfg_mode);
    end
  end

  assign start = cfg_taken && !busy && !done;
  assign err = abs_diff(count, gain_target(gain_sel));

  cbat_burst u_burst (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .start(start),
    .trip_sync(trip_ff[1]),
    .xfer_pulse(xfer_pulse),
    .busy(busy),
    .done(done),
    .count(count)
  );

  // ----------------------------------------
  // Tuning sequence
  // ----------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state <= CBAT_ST_CS;
      cs_sel <= '0;
      parasitic_offset_comp <= '0;
      best_err <= '1;
      best_cs <= '0;
      acc <= '0;
      avg_n <= '0;
      reference <= '0;
    end
    else if (done)
    begin
      // Every decision uses a burst taken after the last code change
      case (state)
        CBAT_ST_CS:
        begin
          if (cs_sel == CBAT_CS_LAST)
          begin
            state <= CBAT_ST_COMP;
            cs_sel <= (err < best_err) ? cs_sel : best_cs;
            parasitic_offset_comp <= '0;
          end
          else
          begin
            cs_sel <= cs_sel + 3'h1;
          end
          if (err < best_err)
          begin
            best_err <= err;
            best_cs <= cs_sel;
          end
        end
        CBAT_ST_COMP:
        begin
          // Compensation lowers capacitance, so count rises per step
          // Extra bit keeps a near-full count from wrapping below the target
          if ({1'b0, count} + {1'b0, CBAT_TUNE_WINDOW} >= {1'b0, CBAT_TUNE_TARGET} ||
              parasitic_offset_comp == CBAT_COMP_LAST)
          begin
            state <= CBAT_ST_AVG;
            acc <= '0;
            avg_n <= '0;
          end
          else
            parasitic_offset_comp <= parasitic_offset_comp + 5'h1;
        end
        CBAT_ST_AVG:
        begin
          if (avg_n == CBAT_AVG_COUNT - 6'h1)
          begin
            reference <= 16'((acc + 22'(count)) / 22'(CBAT_AVG_COUNT));
            state <= CBAT_ST_RUN;
          end
          else
          begin
            acc <= acc + 22'(count);
            avg_n <= avg_n + 6'h1;
          end
        end
        default:
        begin
          // Compensation code is held here until a retune clears it
          if (abs_diff(count, CBAT_TUNE_TARGET) > CBAT_TUNE_WINDOW)
          begin
            state <= CBAT_ST_CS;
            cs_sel <= '0;
            parasitic_offset_comp <= '0;
            best_err <= '1;
            best_cs <= '0;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Detection gating and pin roles
  // ----------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      detect_enable <= 1'b0;
      host_ctrl <= 1'b0;
      touch_detect_pin <= 1'b0;
      touch_detect_pin_oe <= 1'b0;
      proximity_detect_pin <= 1'b0;
      proximity_detect_pin_oe <= 1'b0;
      stream_data <= '0;
    end
    else
    begin
      detect_enable <= (state == CBAT_ST_RUN);
      host_ctrl <= ctrl_ff[1];
      stream_data.tuning <= (state != CBAT_ST_RUN);
      stream_data.cs_sel <= cs_sel;
      stream_data.comp_sel <= parasitic_offset_comp;
      stream_data.burst_count <= count;
      case (mode)
        CBAT_MODE_DUAL:
        begin
          touch_detect_pin <= touch_event && state == CBAT_ST_RUN;
          touch_detect_pin_oe <= 1'b1;
          proximity_detect_pin <= prox_event && state == CBAT_ST_RUN;
          proximity_detect_pin_oe <= 1'b1;
        end
        CBAT_MODE_STREAM:
        begin
          // Both pins released: levels low, output enables off
          touch_detect_pin <= 1'b0;
          touch_detect_pin_oe <= 1'b0;
          proximity_detect_pin <= 1'b0;
          proximity_detect_pin_oe <= 1'b0;
        end
        default:
        begin
          touch_detect_pin <= (touch_event || prox_event) && state == CBAT_ST_RUN;
          touch_detect_pin_oe <= 1'b1;
          proximity_detect_pin <= 1'b0;
          proximity_detect_pin_oe <= 1'b0;
        end
      endcase
    end
  end

endmodule : cbat_tuner
`default_nettype wire

// ### cbat_front_model.sv
`timescale 1ns/1ps
`default_nettype none
module cbat_front
  import cbat_pkg::*;
(
  input wire logic clk_sys, // Clock
  input wire logic sys_rst, // Reset
  input wire logic xfer_pulse, // Transfer strobe
  input wire logic [CBAT_CS_W-1:0] cs_sel, // Cap code
  input wire logic [CBAT_COMP_W-1:0] comp, // Comp code
  output logic burst_trip // Comparator level
);
  logic [3:0] n;
  logic [1:0] hold;
  logic [3:0] need;
  // Short bursts keep the run small; cap 5 gives most counts
  assign need = 4'h2 + (cs_sel == 3'h5 ? 4'h2 : 4'h0) + {3'h0, comp[4]};
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      n <= 4'h0;
      hold <= 2'h0;
      burst_trip <= 1'b0;
    end
    else if (hold != 2'h0)
    begin
      // Held long enough to pass a two-flop synchroniser
      hold <= hold - 2'h1;
      if (hold == 2'h1)
        burst_trip <= 1'b0;
    end
    else if (xfer_pulse)
    begin
      n <= (n + 4'h1 >= need) ? 4'h0 : n + 4'h1;
      if (n + 4'h1 >= need)
      begin
        burst_trip <= 1'b1;
        hold <= 2'h3;
      end
    end
  end
endmodule : cbat_front
`default_nettype wire

// ### cbat_tuner_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module cbat_chk
  import cbat_pkg::*;
(
  input wire logic clk_sys, // Clock
  input wire logic sys_rst, // Reset
  input wire logic [1:0] cfg_mode, // Mode
  input wire logic [CBAT_GAIN_SEL_W-1:0] cfg_gain_sel, // Gain
  input wire logic burst_trip, // Trip
  input wire logic touch_event, // Touch
  input wire logic prox_event, // Prox
  input wire logic host_ctrl_in, // Host pin
  input wire logic xfer_pulse, // Transfer
  input wire logic [CBAT_CS_W-1:0] cs_sel, // Cap code
  input wire logic [CBAT_COMP_W-1:0] parasitic_offset_comp, // Comp
  input wire logic [CBAT_COUNT_W-1:0] reference, // Reference
  input wire logic detect_enable, // Detect on
  input wire logic host_ctrl, // Host sync
  input wire logic touch_detect_pin, // Pin 1
  input wire logic touch_detect_pin_oe, // Pin 1 oe
  input wire logic proximity_detect_pin, // Pin 8
  input wire logic proximity_detect_pin_oe, // Pin 8 oe
  input wire cbat_stream_type stream_data // Stream
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  a_tune_no_detect: assert property (stream_data.tuning |-> !detect_enable)
    else $error("detection on while tuning");
  a_pins_quiet: assert property (!detect_enable && !$past(detect_enable) && !$past(detect_enable, 2)
    |-> $stable(touch_detect_pin) && $stable(proximity_detect_pin)) else $error("pin moved while tuning");
  a_xfer_gap: assert property (xfer_pulse |=> !xfer_pulse[*8])
    else $error("transfer strobes too close");
  a_host_delay: assert property (host_ctrl == $past(host_ctrl_in, 3))
    else $error("host input delay wrong");
  a_comp_step: assert property ($changed(parasitic_offset_comp) && parasitic_offset_comp != 5'h00
    |-> parasitic_offset_comp == $past(parasitic_offset_comp) + 5'h01) else $error("comp not single step");
  // Enable lags state by one cycle, so look at the edge before the last one
  a_run_hold: assert property (detect_enable
    |-> $past(cs_sel) == $past(cs_sel, 2) && $past(parasitic_offset_comp) == $past(parasitic_offset_comp, 2))
    else $error("codes moved in run");
  a_stream_codes: assert property (($stable(cs_sel) && $stable(parasitic_offset_comp))[*3]
    |-> stream_data.cs_sel == cs_sel && stream_data.comp_sel == parasitic_offset_comp)
    else $error("stream codes differ");
  a_retune: assert property ($fell(detect_enable) |-> ##[0:2] stream_data.tuning)
    else $error("tuning not restarted");
endmodule : cbat_chk
bind cbat_tuner cbat_chk u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst), .cfg_mode(cfg_mode),
  .cfg_gain_sel(cfg_gain_sel), .burst_trip(burst_trip), .touch_event(touch_event), .prox_event(prox_event),
  .host_ctrl_in(host_ctrl_in), .xfer_pulse(xfer_pulse), .cs_sel(cs_sel), .reference(reference),
  .parasitic_offset_comp(parasitic_offset_comp), .detect_enable(detect_enable), .host_ctrl(host_ctrl),
  .touch_detect_pin(touch_detect_pin), .touch_detect_pin_oe(touch_detect_pin_oe),
  .proximity_detect_pin(proximity_detect_pin), .proximity_detect_pin_oe(proximity_detect_pin_oe),
  .stream_data(stream_data));
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import cbat_pkg::*;
;
  typedef struct packed {logic [2:0] cs_next; logic [15:0] count;} cbat_row_type;
  logic clk_sys = 1'b0;
  logic sys_rst, burst_trip, touch_event, prox_event, host_ctrl_in, xfer_pulse, detect_enable, host_ctrl;
  logic [1:0] cfg_mode, cfg_gain_sel;
  logic [2:0] cs_sel;
  logic [4:0] parasitic_offset_comp;
  logic [15:0] reference;
  logic tpin, tpin_oe, ppin, ppin_oe;
  cbat_stream_type stream_data;
  int fails = 0;
  int checked = 0;
  int i;
  cbat_row_type rows [7] = '{'{3'h1, 16'h0002}, '{3'h2, 16'h0002}, '{3'h3, 16'h0002}, '{3'h4, 16'h0002},
    '{3'h5, 16'h0002}, '{3'h6, 16'h0004}, '{3'h7, 16'h0002}};
  always #5 clk_sys = ~clk_sys;
  cbat_tuner dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .cfg_mode(cfg_mode), .cfg_gain_sel(cfg_gain_sel),
    .burst_trip(burst_trip), .touch_event(touch_event), .prox_event(prox_event), .host_ctrl_in(host_ctrl_in),
    .xfer_pulse(xfer_pulse), .cs_sel(cs_sel), .parasitic_offset_comp(parasitic_offset_comp),
    .reference(reference), .detect_enable(detect_enable), .host_ctrl(host_ctrl), .touch_detect_pin(tpin),
    .touch_detect_pin_oe(tpin_oe), .proximity_detect_pin(ppin), .proximity_detect_pin_oe(ppin_oe),
    .stream_data(stream_data));
  cbat_front u_front (.clk_sys(clk_sys), .sys_rst(sys_rst), .xfer_pulse(xfer_pulse), .cs_sel(cs_sel),
    .comp(parasitic_offset_comp), .burst_trip(burst_trip));
  // ----
  // Shared tasks
  // ----
  task automatic close_out();
    $display("checks=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wait_on(input int sel, input int lim, input logic [4:0] v);
    for (int k = 0; k < lim; k++)
    begin
      @(posedge clk_sys);
      #1;
      if ((sel == 0 && cs_sel === v[2:0]) || (sel == 1 && parasitic_offset_comp === v) ||
          (sel == 2 && detect_enable === 1'b1) || (sel == 3 && stream_data.tuning === 1'b1))
        return;
    end
    fails++;
    close_out();
  endtask : wait_on
  task automatic do_reset(input logic [1:0] m);
    @(posedge clk_sys);
    cfg_mode <= m;
    sys_rst <= 1'b1;
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
  endtask : do_reset
  initial
  begin
    sys_rst = 1'b1;
    cfg_mode = 2'h0;
    cfg_gain_sel = 2'h1;
    touch_event = 1'b0;
    prox_event = 1'b0;
    host_ctrl_in = 1'b0;
    do_reset(2'h0);
    @(posedge clk_sys);
    // Events and a mode change arrive while tuning runs
    cfg_mode <= 2'h2;
    touch_event <= 1'b1;
    prox_event <= 1'b1;
    host_ctrl_in <= 1'b1;
    for (i = 0; i < 7; i++)
    begin
      wait_on(0, 1000, {2'h0, rows[i].cs_next});
      // Streamed count follows the burst result by one cycle
      @(posedge clk_sys);
      #1;
      chk(stream_data.burst_count, rows[i].count);
      chk(16'(tpin), 16'h0000);
    end
    chk(16'(ppin_oe), 16'h0000);
    chk(16'(tpin_oe), 16'h0001);
    chk(16'(host_ctrl), 16'h0001);
    wait_on(1, 2000, 5'h01);
    @(posedge clk_sys);
    #1;
    chk(16'(cs_sel), 16'h0005);
    chk(16'(stream_data.cs_sel), 16'h0005);
    chk(stream_data.burst_count, 16'h0004);
    wait_on(2, 60000, 5'h00);
    chk(16'(parasitic_offset_comp), 16'h001f);
    chk(reference, 16'h0005);
    chk(16'(stream_data.tuning), 16'h0000);
    chk(16'(stream_data.comp_sel), 16'h001f);
    chk(16'(tpin), 16'h0001);
    wait_on(3, 2000, 5'h00);
    chk(16'(detect_enable), 16'h0000);
    chk(16'(tpin), 16'h0000);
    host_ctrl_in <= 1'b0;
    repeat (4) @(posedge clk_sys);
    do_reset(2'h1);
    wait_on(0, 1000, 5'h01);
    chk(16'(ppin_oe), 16'h0001);
    chk(16'(ppin), 16'h0000);
    do_reset(2'h2);
    wait_on(0, 1000, 5'h01);
    chk(16'(tpin_oe), 16'h0000);
    chk(16'(stream_data.tuning), 16'h0001);
    close_out();
  end
endmodule : tb_top
`default_nettype wire
